// *** hw/pdl_top.sv ***
// Predecoder stall, fusion, decoder steering and loop replay model
// How it works
// - Instructions up to fifteen bytes accepted
// - Line predecode one cycle, six with prefix
// - Bytes 66 and 67 trigger slow path
// - Fixed sixteen bit immediate avoids slow path stalls, not false stall
// - REX prefix in 64-bit never stalls
// - Line crossing cases stall twice
// - Double stall costs eleven cycles total
// - Prefixed F7 at offset 14 stalls
// - False stall holds six cycles, like slow path
// - Loop fits four fetches, eighteen instructions
// - Loop has at most four taken, no return
// - Qualified loop replays from instruction queue
// - No fusion for memory-immediate compare
// - Test fuses more often than compare
// - Single decoder mode: one per clock, ROM
// - First decoder: four micro-ops, fifteen bytes
// - Other decoders: one micro-op, seven bytes
// - Over four micro-ops takes several cycles
// - Multi-prefix goes to first decoder, slower
// - Compare or test then branch, one pair
// - Compare fuses carry/zero jumps; none 64-bit
`timescale 1ns/10ps
module pdl_top
  import pdl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic line_valid_in,
  output logic line_ready_out,
  input wire pdl_line_t line_in,
  output logic pre_valid_out,
  output logic [1:0] pre_stalls_out,
  input wire logic three_dec_in,
  input wire logic insn_valid_in,
  input wire pdl_insn_t insn_in,
  input wire pdl_insn_t insn2_in,
  input wire logic [1:0] insn_slot_in,
  input wire logic loop_back_in,
  input wire logic redirect_in,
  output logic dec_valid_out,
  input wire logic dec_ready_in,
  output pdl_dec_t dec_out,
  output logic replay_out
);
  localparam int DW = $bits(pdl_dec_t);
  pdl_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] stl_r, stl_nxt;
  logic pv_r, pv_nxt;
  logic length_changing_prefix, lcp_real, dbl, fls, take_line;

  // Length-changing prefix detection on the incoming line
  always_comb
  begin
    length_changing_prefix = pdl_has_lcp(line_in.bytes);
    // A fixed-encoding sixteen_bit_immediate needs no slow path; REX is not a prefix here
    lcp_real = length_changing_prefix && !line_in.has_sixteen_bit_immediate_fixed;
    dbl = lcp_real && (line_in.modrm_sib_split ||
          (line_in.start_off == 4'(DOUBLE_OFFSET) && line_in.reg_disp8));
    fls = length_changing_prefix && line_in.start_off == 4'(FALSE_OFFSET) &&
          pdl_byte_is(line_in.bytes, FALSE_OFFSET + 1, F7_OPC);
  end

  assign line_ready_out = st_r == ST_IDLE;
  assign take_line = line_valid_in && line_ready_out;

  // Predecode timing state machine
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    stl_nxt = stl_r;
    pv_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE:
      begin
        if (take_line)
        begin
          if (dbl)
          begin
            st_nxt = ST_SLOW;
            cnt_nxt = 4'(DOUBLE_CYCLES - 1);
            stl_nxt = 2'h2;
          end
          else if (fls)
          begin
            st_nxt = ST_WAIT;
            cnt_nxt = 4'(SLOW_CYCLES - 1);
            stl_nxt = 2'h1;
          end
          else if (lcp_real)
          begin
            st_nxt = ST_SLOW;
            cnt_nxt = 4'(SLOW_CYCLES - 1);
            stl_nxt = 2'h1;
          end
          else
          begin
            pv_nxt = 1'b1;
            stl_nxt = 2'h0;
          end
        end
      end
      ST_SLOW, ST_WAIT:
      begin
        cnt_nxt = 4'(cnt_r - 1'b1);
        if (cnt_r == 4'h1)
        begin
          st_nxt = ST_IDLE;
          pv_nxt = 1'b1;
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      st_r <= ST_IDLE;
      cnt_r <= CNT_ZERO;
      stl_r <= 2'h0;
      pv_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      stl_r <= stl_nxt;
      pv_r <= pv_nxt;
    end
  end

  assign pre_valid_out = pv_r;
  assign pre_stalls_out = stl_r;

  // Decode steering, fusion and cycle cost
  pdl_dec_t dw;
  logic fuse_ok, legal, fifo_rdy;
  always_comb
  begin
    legal = insn_in.len != 4'h0 && insn_in.len <= 4'(MAX_INSN_BYTES);
    fuse_ok = insn2_in.is_jcc && !insn_in.mem_imm && !line_in.mode64 &&
              (insn_in.is_test || (insn_in.is_cmp && insn2_in.jcc_cf_zf));
    dw = '0;
    dw.fused = fuse_ok;
    dw.uops = fuse_ok ? 4'h1 : insn_in.uops;
    dw.rom = insn_in.uops > 4'(DEC0_MAX_UOPS);
    dw.cycles = 4'h1;
    if (!three_dec_in)
    begin
      dw.slot = 2'h0;
    end
    else if (insn_in.npfx > 2'h1 || insn_in.uops != 4'h1 ||
             insn_in.len > 4'(DECN_MAX_BYTES))
    begin
      dw.slot = 2'h0;
    end
    else
    begin
      dw.slot = insn_slot_in;
    end
    if (insn_in.uops > 4'(DEC0_MAX_UOPS))
    begin
      // Widen before rounding up so 13 to 15 micro-ops do not wrap
      dw.cycles = 4'(({1'b0, insn_in.uops} + 5'h3) >> 2);
    end
    if (insn_in.npfx > 2'h1)
    begin
      dw.cycles = 4'(dw.cycles + 4'h1);
    end
  end

  pdl_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(insn_valid_in && legal),
    .in_ready_out(fifo_rdy),
    .in_data_in(dw),
    .out_valid_out(dec_valid_out),
    .out_ready_in(dec_ready_in),
    .out_data_out(dec_out)
  );

  // Loop replay detector bookkeeping
  logic [4:0] ni_r, ni_nxt;
  logic [2:0] nf_r, nf_nxt, nt_r, nt_nxt;
  logic bad_r, bad_nxt, rp_r, rp_nxt;
  always_comb
  begin
    ni_nxt = ni_r;
    nf_nxt = nf_r;
    nt_nxt = nt_r;
    bad_nxt = bad_r;
    rp_nxt = rp_r;
    if (take_line && nf_r != 3'h7)
    begin
      nf_nxt = 3'(nf_r + 1'b1);
    end
    if (insn_valid_in && fifo_rdy)
    begin
      if (ni_r != 5'h1F)
      begin
        ni_nxt = 5'(ni_r + 1'b1);
      end
      if (insn_in.taken && nt_r != 3'h7)
      begin
        nt_nxt = 3'(nt_r + 1'b1);
      end
      bad_nxt = bad_r || insn_in.is_ret;
    end
    if (loop_back_in)
    begin
      rp_nxt = !bad_nxt && ni_nxt <= 5'(LOOP_MAX_INSNS) &&
               nf_nxt <= 3'(LOOP_MAX_FETCHES) &&
               nt_nxt <= 3'(LOOP_MAX_TAKEN);
      ni_nxt = 5'h0;
      nf_nxt = 3'h0;
      nt_nxt = 3'h0;
      bad_nxt = 1'b0;
    end
    if (redirect_in)
    begin
      rp_nxt = 1'b0;
      ni_nxt = 5'h0;
      nf_nxt = 3'h0;
      nt_nxt = 3'h0;
      bad_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ni_r <= 5'h0;
      nf_r <= 3'h0;
      nt_r <= 3'h0;
      bad_r <= 1'b0;
      rp_r <= 1'b0;
    end
    else
    begin
      ni_r <= ni_nxt;
      nf_r <= nf_nxt;
      nt_r <= nt_nxt;
      bad_r <= bad_nxt;
      rp_r <= rp_nxt;
    end
  end

  assign replay_out = rp_r;

  // Checks
  chk_single_stall: assert property (@(posedge clk_in) disable iff (!rstn_in)
    take_line && lcp_real && !dbl && !fls |=> !pv_r [*5] ##1 pv_r)
    else $error("single stall not six cycles");
  chk_double_stall: assert property (@(posedge clk_in) disable iff (!rstn_in)
    take_line && dbl |=> !pv_r [*8] ##2 !pv_r ##1 pv_r)
    else $error("double stall not eleven cycles");
  chk_fast_line: assert property (@(posedge clk_in) disable iff (!rstn_in)
    take_line && !length_changing_prefix |=> pv_r && stl_r == 2'h0)
    else $error("fast line not one cycle");
  chk_false_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
    take_line && fls && !dbl |=> st_r == ST_WAIT && !line_ready_out)
    else $error("false stall missing");
  chk_stall_ready: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r != ST_IDLE |-> !line_ready_out && !pv_r)
    else $error("ready during stall");
  chk_sixteen_bit_immediate_free: assert property (@(posedge clk_in) disable iff (!rstn_in)
    take_line && line_in.has_sixteen_bit_immediate_fixed && !fls |=> st_r == ST_IDLE)
    else $error("sixteen_bit_immediate stalled");
  chk_no_fuse64: assert property (@(posedge clk_in) disable iff (!rstn_in)
    line_in.mode64 || insn_in.mem_imm |-> !dw.fused)
    else $error("fusion not allowed");
  chk_slot_limit: assert property (@(posedge clk_in) disable iff (!rstn_in)
    dw.slot != 2'h0 |-> insn_in.uops == 4'h1 && insn_in.len <= 4'h7)
    else $error("slot limit broken");
  chk_redirect_drop: assert property (@(posedge clk_in) disable iff (!rstn_in)
    redirect_in |=> !replay_out)
    else $error("replay after redirect");
  chk_multi_cycle: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_in.uops > 4'(DEC0_MAX_UOPS) |-> dw.cycles > 4'h1)
    else $error("long instruction decoded in one cycle");
  chk_prefix_slot: assert property (@(posedge clk_in) disable iff (!rstn_in)
    insn_in.npfx > 2'h1 |-> dw.slot == 2'h0 && dw.cycles > 4'h1)
    else $error("multi-prefix not on first decoder");
  chk_ret_blocks: assert property (@(posedge clk_in) disable iff (!rstn_in)
    loop_back_in && !redirect_in && bad_nxt |=> !replay_out)
    else $error("loop with return replayed");
  cov_slow: cover property (@(posedge clk_in) take_line && lcp_real);
  cov_double: cover property (@(posedge clk_in) take_line && dbl);
  cov_false: cover property (@(posedge clk_in) take_line && fls);
  cov_fused: cover property (@(posedge clk_in) insn_valid_in && dw.fused);
  cov_replay: cover property (@(posedge clk_in) !replay_out ##1 replay_out);
endmodule

// *** shared/pdl_pkg.sv ***
// Package: constants, types and helpers for the predecode timing block
package pdl_pkg;
  localparam int LINE_BYTES = 16;
  localparam int MAX_INSN_BYTES = 15;
  localparam int SLOW_CYCLES = 6;
  localparam int DOUBLE_CYCLES = 11;
  localparam int FALSE_OFFSET = 14;
  localparam int DOUBLE_OFFSET = 13;
  localparam int LOOP_MAX_FETCHES = 4;
  localparam int LOOP_MAX_INSNS = 18;
  localparam int LOOP_MAX_TAKEN = 4;
  localparam int DEC0_MAX_UOPS = 4;
  localparam int DECN_MAX_BYTES = 7;
  localparam logic [7:0] OPSIZE_PFX = 8'h66;
  localparam logic [7:0] ADSIZE_PFX = 8'h67;
  localparam logic [7:0] F7_OPC = 8'hF7;
  localparam logic [3:0] REX_NIB = 4'h4;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // One fetch line with per-line hints from fetch
  typedef struct packed {
    logic [127:0] bytes;
    logic [3:0] start_off;   // Offset of first instruction start
    logic modrm_sib_split;   // ModR/M and SIB straddle the line end
    logic reg_disp8;         // Register plus byte displacement form
    logic has_sixteen_bit_immediate_fixed;   // Fixed encoding sixteen_bit_immediate, no prefix needed
    logic mode64;
  } pdl_line_t;

  // One decoded instruction descriptor
  typedef struct packed {
    logic [3:0] len;         // Length in bytes, 1 to 15
    logic [3:0] uops;
    logic [1:0] npfx;
    logic is_cmp;
    logic is_test;
    logic mem_imm;
    logic is_jcc;
    logic jcc_cf_zf;         // Jump checks only carry or zero
    logic taken;
    logic is_ret;
  } pdl_insn_t;

  typedef struct packed {
    logic [1:0] slot;        // Decoder slot used
    logic fused;
    logic rom;               // Micro-ops come from microcode ROM
    logic [3:0] uops;
    logic [3:0] cycles;
  } pdl_dec_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SLOW = 3'b010,
    ST_WAIT = 3'b100
  } pdl_state_t;

  // True when any byte is a length-changing prefix
  function automatic logic pdl_has_lcp(input logic [127:0] b);
    logic r;
    r = 1'b0;
    for (int i = 0; i < LINE_BYTES; i++)
    begin
      if (b[i*8 +: 8] == OPSIZE_PFX || b[i*8 +: 8] == ADSIZE_PFX)
      begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // True when a byte sits at a given offset
  function automatic logic pdl_byte_is(input logic [127:0] b,
                                       input int off,
                                       input logic [7:0] v);
    return b[off*8 +: 8] == v;
  endfunction
endpackage

// *** hw/pdl_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pdl_fifo
  import pdl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Handshake and pointer update
  always_comb
  begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + push - pop);
  end

  assign in_ready_out = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_out = cnt_r != '0;
  assign out_data_out = mem_r[rp_r];

  // Storage and pointers
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push)
    begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule

// *** verif/pdl_fetch_model.sv ***
// Fetch unit model: offers queued lines and holds each until taken
`timescale 1ns/10ps
module pdl_fetch_model
  import pdl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic line_ready_in,
  output logic line_valid_out,
  output pdl_line_t line_out
);
  pdl_line_t pend_q[$];
  logic take_r;
  logic run_r;
  initial
  begin
    line_valid_out = 1'b0;
    line_out = '0;
    take_r = 1'b0;
    run_r = 1'b0;
  end
  // Queue one line for delivery
  task automatic push(input pdl_line_t l);
    pend_q.push_back(l);
  endtask
  // Handshake sampled mid-cycle, where both sides have settled
  always @(negedge clk_in)
  begin
    take_r = line_valid_out && line_ready_in;
    run_r = rstn_in;
  end
  // Drop a taken line, then offer the next just after the edge
  always @(posedge clk_in)
  begin
    if (take_r)
    begin
      void'(pend_q.pop_front());
    end
    #1;
    if (run_r && pend_q.size() != 0)
    begin
      line_out = pend_q[0];
      line_valid_out = 1'b1;
    end
    else
    begin
      line_valid_out = 1'b0;
      line_out.bytes = ~line_out.bytes; // Idle bytes invert each idle cycle, matching the last line again every second one
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the predecode timing block
`timescale 1ns/10ps
module testbench;
  import pdl_pkg::*;
  localparam logic [6:0] CMPR = 7'h40;
  localparam logic [6:0] CMPM = 7'h50;
  localparam logic [6:0] TST = 7'h20;
  localparam logic [6:0] JS = 7'h08;
  localparam logic [6:0] JU = 7'h0C;
  logic clk_in, rstn_in, line_valid, line_ready, pre_valid, three_dec;
  logic insn_valid, loop_back, redirect, dec_valid, dec_ready, replay;
  logic [1:0] pre_stalls, insn_slot;
  pdl_line_t line;
  pdl_insn_t insn, insn2;
  pdl_dec_t dec;
  int n_fail, n_tests;
  // Free-running core clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  pdl_fetch_model fetch (.clk_in(clk_in), .rstn_in(rstn_in),
    .line_ready_in(line_ready), .line_valid_out(line_valid),
    .line_out(line));
  pdl_top #(.FIFO_DEPTH(8)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .line_valid_in(line_valid), .line_ready_out(line_ready),
    .line_in(line), .pre_valid_out(pre_valid),
    .pre_stalls_out(pre_stalls), .three_dec_in(three_dec),
    .insn_valid_in(insn_valid), .insn_in(insn), .insn2_in(insn2),
    .insn_slot_in(insn_slot), .loop_back_in(loop_back),
    .redirect_in(redirect), .dec_valid_out(dec_valid),
    .dec_ready_in(dec_ready), .dec_out(dec), .replay_out(replay));
  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic miss(input logic [15:0] g, input logic [15:0] e);
    n_fail++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) miss(g, e);
  endtask
  task automatic chk_num(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) miss(g, e);
  endtask
  task automatic chk_dec(input pdl_dec_t g, input pdl_dec_t e);
    n_tests++;
    if (g !== e) miss(g, e);
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  // Line of filler bytes with two chosen bytes
  function automatic logic [127:0] lb(input int p, input logic [7:0] v,
                                      input int q, input logic [7:0] w);
    logic [127:0] b;
    b = {16{8'h90}};
    b[p*8 +: 8] = v;
    b[q*8 +: 8] = w;
    return b;
  endfunction
  function automatic pdl_insn_t mi(input logic [3:0] l,
    input logic [3:0] u, input logic [1:0] p, input logic [6:0] f);
    return pdl_insn_t'({l, u, p, f});
  endfunction
  function automatic pdl_dec_t md(input logic [1:0] s, input logic fu,
    input logic r, input logic [3:0] u, input logic [3:0] c);
    return pdl_dec_t'({s, fu, r, u, c});
  endfunction
  // Offer a line, time its length decode and check the stall count
  task automatic line_case(input logic [127:0] b, input logic [3:0] off,
    input logic [3:0] hints, input logic [7:0] cyc, input logic [1:0] st);
    int i;
    fetch.push(pdl_line_t'({b, off, hints}));
    #1;
    for (i = 0; i < 30 && !(line_valid && line_ready); i++)
    begin
      @(posedge clk_in);
      #2;
    end
    if (i == 30)
    begin
      miss(16'h0, 16'h1);
      close_out();
    end
    for (i = 1; i < 30; i++)
    begin
      @(posedge clk_in);
      #2;
      if (pre_valid === 1'b1) break;
      chk_bit(line_ready, 1'b0);
    end
    chk_num(8'(i), cyc);
    if (i == 30) close_out();
    chk_num({6'h0, pre_stalls}, {6'h0, st});
    tick();
    chk_bit(pre_valid, 1'b0);
  endtask
  // One instruction pulse (with its follower for fusion)
  task automatic send(input pdl_insn_t a, input pdl_insn_t b,
                      input logic [1:0] s);
    insn = a;
    insn2 = b;
    insn_slot = s;
    insn_valid = 1'b1;
    tick();
    insn_valid = 1'b0;
  endtask
  task automatic dec_case(input logic td, input pdl_insn_t a,
    input pdl_insn_t b, input logic [1:0] s, input pdl_dec_t e);
    three_dec = td;
    send(a, b, s);
    chk_bit(dec_valid, 1'b1);
    chk_dec(dec, e);
    tick();
  endtask
  // Loop body of nl lines and ni instructions, then evaluate replay
  task automatic loop_case(input int nl, input int ni, input int nt,
                           input logic rt, input logic e);
    int k;
    redirect = 1'b1;
    tick();
    redirect = 1'b0;
    loop_back = 1'b1;
    tick();
    loop_back = 1'b0;
    redirect = 1'b1;
    tick();
    redirect = 1'b0;
    for (k = 0; k < nl; k++) line_case(lb(0, 8'h90, 0, 8'h90), 4'h0,
                                       4'h0, 8'h1, 2'h0);
    for (k = 0; k < ni; k++)
    begin
      send(mi(4'h2, 4'h1, 2'h0, {4'h1, 1'b0, k < nt,
           rt && k == ni - 1}), '0, 2'h0);
      tick();
    end
    loop_back = 1'b1;
    tick();
    loop_back = 1'b0;
    chk_bit(replay, e);
    redirect = 1'b1;
    tick();
    redirect = 1'b0;
    tick();
    chk_bit(replay, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    int k;
    {rstn_in, three_dec, insn_valid, loop_back, redirect} = '0;
    {insn, insn2, insn_slot} = '0;
    dec_ready = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (8) tick();
    rstn_in = 1'b1;
    chk_bit(line_ready, 1'b1);
    chk_bit(replay, 1'b0);
    line_case(lb(0, 8'h90, 0, 8'h90), 4'h0, 4'h0, 8'h1, 2'h0);
    line_case(lb(3, 8'h66, 0, 8'h90), 4'h0, 4'h0, 8'h6, 2'h1);
    line_case(lb(3, 8'h67, 0, 8'h90), 4'h0, 4'h0, 8'h6, 2'h1);
    line_case(lb(3, 8'h66, 0, 8'h90), 4'h0, 4'h2, 8'h1, 2'h0);
    line_case(lb(5, 8'h66, 6, 8'h81), 4'h5, 4'h8, 8'hB, 2'h2);
    line_case(lb(13, 8'h66, 14, 8'h81), 4'hD, 4'h4, 8'hB, 2'h2);
    line_case(lb(14, 8'h66, 15, 8'hF7), 4'hE, 4'h0, 8'h6, 2'h1);
    line_case(lb(3, 8'h48, 0, 8'h90), 4'h0, 4'h1, 8'h1, 2'h0);
    dec_case(1, mi(2, 1, 0, TST), mi(2, 1, 0, JS), 1,
             md(1, 0, 0, 1, 1));
    line_case(lb(0, 8'h90, 0, 8'h90), 4'h0, 4'h0, 8'h1, 2'h0);
    dec_case(1, mi(7, 1, 0, CMPM), mi(2, 1, 0, JS), 1,
             md(1, 0, 0, 1, 1));
    dec_case(1, mi(3, 1, 0, CMPR), mi(2, 1, 0, JU), 1,
             md(1, 1, 0, 1, 1));
    dec_case(1, mi(2, 1, 0, TST), mi(2, 1, 0, JS), 1,
             md(1, 1, 0, 1, 1));
    dec_case(1, mi(3, 1, 0, CMPR), mi(2, 1, 0, JS), 1,
             md(1, 0, 0, 1, 1));
    dec_case(0, mi(2, 1, 0, 0), '0, 2, md(0, 0, 0, 1, 1));
    dec_case(1, mi(7, 1, 0, 0), '0, 2, md(2, 0, 0, 1, 1));
    dec_case(1, mi(8, 1, 0, 0), '0, 1, md(0, 0, 0, 1, 1));
    dec_case(1, mi(3, 2, 0, 0), '0, 1, md(0, 0, 0, 2, 1));
    dec_case(1, mi(15, 4, 0, 0), '0, 2, md(0, 0, 0, 4, 1));
    dec_case(1, mi(3, 6, 0, 0), '0, 1, md(0, 0, 1, 6, 2));
    dec_case(1, mi(3, 13, 0, 0), '0, 1, md(0, 0, 1, 13, 4));
    dec_case(1, mi(3, 1, 2, 0), '0, 1, md(0, 0, 0, 1, 2));
    send(mi(0, 1, 0, 0), '0, 0);
    chk_bit(dec_valid, 1'b0);
    // Fill the queue past its depth while the consumer stalls
    dec_ready = 1'b0;
    for (k = 0; k < 9; k++)
    begin
      send(mi(2, 1, 0, 0), '0, 0);
      tick();
    end
    dec_ready = 1'b1;
    for (k = 0; k < 20 && dec_valid === 1'b1; k++) tick();
    chk_num(8'(k), 8'h8);
    if (k == 20) close_out();
    loop_case(2, 3, 1, 0, 1);
    loop_case(4, 18, 4, 0, 1);
    loop_case(5, 3, 1, 0, 0);
    loop_case(1, 19, 0, 0, 0);
    loop_case(1, 5, 5, 0, 0);
    loop_case(1, 3, 1, 1, 0);
    close_out();
  end
endmodule
